// >>> hw/drwe_pkg.sv
// Operation
// - PID words are percent times one hundred; 10000 means 100.00 percent.
// - Target and feedback take 0..100.00 percent; error takes -100..100 percent.
// - A PID word outside its range is ignored; the held setting stays.
// - PID and torque words act only with PID selection 50, 51, 60 or 61.
// - Torque word latches on a frequency write request, in vector torque mode only.
// - Accepted torque updates the volatile and, on non-volatile write, stored parameter.
// - An instruction slot holding HFFFF is skipped on execute.
// - Slot upper byte is link expansion setting, lower byte the instruction code.
// - Slot 10 pairs with data 11, 12 with 13, through 18 with 19.
// - With monitor request on, first monitor shows quantity of selector low byte.
// - Selector upper byte zero shows output frequency, else the selected quantity.
// - Position control with pulse selection not 9999 shows pulse monitor instead.
// - With expansion setting zero, frequency write yields the full reply word.
// - With expansion setting zero, execute yields full instruction reply, zero if normal.
// - Expansion settings other than 0 and 100 split reply: frequency low byte, instruction high byte.
// - A normal reply places the primary instruction result in read data.
// - Matching frequency write done bit rises once the write is carried out.
// - Instruction runs only after execute request; done bit rises when finished.
package drwe_pkg;

   localparam logic [7:0] A_MSEL  = 8'h00;
   localparam logic [7:0] A_PINS  = 8'h04;
   localparam logic [7:0] A_PWD   = 8'h08;
   localparam logic [7:0] A_PTGT  = 8'h0C;
   localparam logic [7:0] A_PFB   = 8'h10;
   localparam logic [7:0] A_PERR  = 8'h14;
   localparam logic [7:0] A_TRQ   = 8'h18;
   localparam logic [7:0] A_FREQ  = 8'h1C;
   localparam logic [7:0] A_HS    = 8'h20;
   localparam logic [7:0] A_CFG   = 8'h24;
   localparam logic [7:0] A_PLS   = 8'h28;
   localparam logic [7:0] A_SLOT  = 8'h40;
   localparam logic [7:0] A_SLEND = 8'h68;
   localparam logic [7:0] A_MON1  = 8'h80;
   localparam logic [7:0] A_MON2  = 8'h84;
   localparam logic [7:0] A_REPLY = 8'h88;
   localparam logic [7:0] A_RDATA = 8'h8C;
   localparam logic [7:0] A_STAT  = 8'h90;
   localparam logic [7:0] A_TVOL  = 8'h94;
   localparam logic [7:0] A_TNV   = 8'h98;
   localparam logic [7:0] A_FVOL  = 8'h9C;
   localparam logic [7:0] A_FNV   = 8'hA0;
   localparam logic [7:0] A_SREP  = 8'hC0;
   localparam logic [7:0] A_SREND = 8'hD4;

   localparam int NSLOT   = 5;
   localparam int NSWORD  = 10;
   localparam int PARAM_N = 32;

   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [15:0] SLOT_OFF  = 16'hFFFF;
   localparam logic [15:0] FREQ_MAX  = 16'h9C40;
   localparam logic [15:0] PULSE_OFF = 16'h270F;
   localparam logic signed [15:0] PID_MAX = 16'sh2710;
   localparam logic signed [15:0] PID_MIN = 16'shD8F0;

   localparam logic [7:0] PID_SEL_A = 8'h32;
   localparam logic [7:0] PID_SEL_B = 8'h33;
   localparam logic [7:0] PID_SEL_C = 8'h3C;
   localparam logic [7:0] PID_SEL_D = 8'h3D;
   localparam logic [7:0] EXT_ZERO  = 8'h00;
   localparam logic [7:0] EXT_ALT   = 8'h64;
   localparam logic [7:0] EXT_TRQ_A = 8'h0E;
   localparam logic [7:0] EXT_TRQ_B = 8'h12;
   localparam logic [7:0] EXT_TRQ_C = 8'h76;
   localparam logic [3:0] TSRC_A    = 4'h3;
   localparam logic [3:0] TSRC_B    = 4'h5;
   localparam logic [3:0] CTRL_POS  = 4'h3;

   localparam logic [7:0] RC_OK    = 8'h00;
   localparam logic [7:0] RC_MODE  = 8'h01;
   localparam logic [7:0] RC_SEL   = 8'h02;
   localparam logic [7:0] RC_RANGE = 8'h03;

   localparam logic [7:0] MON_FREQ = 8'h01;
   localparam logic [7:0] MON_CUR  = 8'h02;
   localparam logic [7:0] MON_VOLT = 8'h03;
   localparam logic [7:0] MON_PLS  = 8'h04;

   typedef struct packed {
      logic exe;
      logic fwn;
      logic fwv;
      logic mon;
   } drwe_hs_t;

   typedef struct packed {
      logic       vec;
      logic [3:0] ctrl;
      logic [3:0] tsrc;
      logic [7:0] pid;
      logic [7:0] ext;
   } drwe_cfg_t;

   typedef struct packed {
      logic [7:0]  ext;
      logic [7:0]  code;
      logic [15:0] data;
   } drwe_ins_t;

   typedef struct packed {
      logic [15:0] code;
      logic [15:0] data;
   } drwe_rep_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PRIM, ST_PWAIT, ST_SLOT, ST_SWAIT, ST_DONE
   } drwe_st_t;

   function automatic logic drwe_pid_ok(input logic [15:0] v,
                                        input logic sgn);
      logic signed [15:0] s;
      s = $signed(v);
      drwe_pid_ok = (s <= PID_MAX) && (sgn ? (s >= PID_MIN) : !s[15]);
   endfunction

   function automatic logic drwe_pid_on(input logic [7:0] s);
      drwe_pid_on = (s == PID_SEL_A) || (s == PID_SEL_B) ||
                    (s == PID_SEL_C) || (s == PID_SEL_D);
   endfunction

   function automatic logic drwe_plain(input logic [7:0] e);
      drwe_plain = (e == EXT_ZERO) || (e == EXT_ALT);
   endfunction

endpackage

// >>> hw/drwe_instr_exec.sv
`timescale 1ns/1ps
module drwe_instr_exec
   import drwe_pkg::*;
(
   input  wire logic      core_clk,
   input  wire logic      sys_rst,
   input  wire logic      start,
   input  wire drwe_ins_t req,
   input  wire logic      running,
   output logic           done,
   output drwe_rep_t      rep
);

   logic [15:0] mem_q [PARAM_N];

   // Bit 7 of the code asks for a write; bits 6..4 must be clear.
   wire       wr_op = req.code[7];
   wire       bad   = (req.code[6:4] != 3'h0);
   wire [4:0] idx   = {req.ext[0], req.code[3:0]};
   wire [7:0] rc    = bad ? RC_SEL : (wr_op && running) ? RC_MODE : RC_OK;
   wire       ok    = (rc == RC_OK);

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         done <= 1'b0;
         rep  <= '0;
         for (int i = 0; i < PARAM_N; i++)
            mem_q[i] <= RST_WORD;
      end
      else
      begin
         done <= start;
         if (start)
         begin
            rep.code <= {8'h00, rc};
            rep.data <= (ok && !wr_op) ? mem_q[idx] : RST_WORD;
            if (ok && wr_op)
               mem_q[idx] <= req.data;
         end
      end
   end

endmodule // drwe_instr_exec

// >>> hw/drwe_core.sv
`timescale 1ns/1ps
module drwe_core
   import drwe_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        drive_running,
   input  wire logic [15:0] drive_out_freq,
   input  wire logic [15:0] drive_out_current,
   input  wire logic [15:0] drive_out_voltage,
   input  wire logic [15:0] drive_pulse_mon,
   output logic      [15:0] freq_volatile_out,
   output logic      [15:0] freq_nonvolatile_out,
   output logic      [15:0] torque_value_volatile_param,
   output logic      [15:0] torque_value_nonvolatile_param,
   output logic      [15:0] pid_target_out,
   output logic      [15:0] pid_feedback_out,
   output logic      [15:0] pid_error_out,
   output logic             freq_write_volatile_done,
   output logic             freq_write_nonvolatile_done,
   output logic             instruction_done
);

   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [15:0] msel_q;
   logic [15:0] pins_q;
   logic [15:0] pwd_q;
   logic [15:0] trqw_q;
   logic [15:0] freq_q;
   logic [15:0] pls_q;
   drwe_hs_t    hs_q;
   drwe_hs_t    hs_prev_q;
   drwe_cfg_t   cfg_q;
   logic [15:0] slot_q [NSWORD];
   logic [15:0] ptgt_q;
   logic [15:0] pfb_q;
   logic [15:0] perr_q;
   logic [15:0] mon1_q;
   logic [15:0] mon2_q;
   logic [15:0] reply_q;
   logic [15:0] rdata_q;
   logic [15:0] tvol_q;
   logic [15:0] tnv_q;
   logic [15:0] fvol_q;
   logic [15:0] fnv_q;
   logic        fwv_done_q;
   logic        fwn_done_q;
   logic        ins_done_q;
   logic [15:0] srep_q [NSLOT];
   drwe_st_t    state_q;
   logic [2:0]  idx_q;
   logic        x_done;
   drwe_rep_t   x_rep;

   assign prdata                         = prdata_q;
   assign pready                         = pready_q;
   assign pslverr                        = pslverr_q;
   assign freq_volatile_out              = fvol_q;
   assign freq_nonvolatile_out           = fnv_q;
   assign torque_value_volatile_param    = tvol_q;
   assign torque_value_nonvolatile_param = tnv_q;
   assign pid_target_out                 = ptgt_q;
   assign pid_feedback_out               = pfb_q;
   assign pid_error_out                  = perr_q;
   assign freq_write_volatile_done       = fwv_done_q;
   assign freq_write_nonvolatile_done    = fwn_done_q;
   assign instruction_done               = ins_done_q;

   // Bus decode. Every access has one wait-free access phase after setup.
   wire       setup    = psel && !penable;
   wire       wr       = psel && penable && pwrite && pready_q;
   wire [7:0] slot_off = paddr - A_SLOT;
   wire [3:0] slot_i   = slot_off[5:2];
   wire [7:0] srep_off = paddr - A_SREP;
   wire [2:0] srep_i   = srep_off[4:2];
   wire       aligned  = (paddr[1:0] == 2'b00);
   wire       slot_hit = aligned && paddr >= A_SLOT && paddr < A_SLEND;
   wire       srep_hit = aligned && paddr >= A_SREP && paddr < A_SREND;
   wire [15:0] wd      = pwdata[15:0];

   wire pid_on  = drwe_pid_on(cfg_q.pid);
   wire plain   = drwe_plain(cfg_q.ext);
   wire pid_wr  = wr && pid_on;

   // Handshake edges; a request counts once per rise of its bit.
   wire fwv_rise = hs_q.fwv && !hs_prev_q.fwv;
   wire fwn_rise = hs_q.fwn && !hs_prev_q.fwn;
   wire fw_go    = fwv_rise || fwn_rise;
   wire exe_rise = hs_q.exe && !hs_prev_q.exe;

   wire trq_ext  = (cfg_q.ext == EXT_TRQ_A) || (cfg_q.ext == EXT_TRQ_B) ||
                   (cfg_q.ext == EXT_TRQ_C);
   wire trq_src  = (cfg_q.tsrc == TSRC_A) || (cfg_q.tsrc == TSRC_B);
   wire trq_mode = cfg_q.vec && trq_ext && trq_src && pid_on;
   // Source B takes only non-negative torque; source A takes full range.
   wire trq_ok   = (cfg_q.tsrc == TSRC_B) ? !trqw_q[15] : 1'b1;
   wire freq_ok  = (freq_q <= FREQ_MAX);
   wire [7:0] fw_rc = (trq_mode ? trq_ok : freq_ok) ? RC_OK : RC_RANGE;

   wire pos_pulse = (cfg_q.ctrl == CTRL_POS) && (pls_q != PULSE_OFF);

   // Instruction sequencing toward the executor.
   wire [3:0]  sw_i     = {idx_q, 1'b0};
   wire [15:0] slot_cmd = slot_q[sw_i];
   wire        slot_end = (idx_q == 3'(NSLOT));
   wire        slot_off_w = (slot_cmd == SLOT_OFF);
   wire        x_start  = (state_q == ST_PRIM) ||
                          (state_q == ST_SLOT && !slot_end && !slot_off_w);
   wire        prim_cap = (state_q == ST_PWAIT) && x_done;
   wire        slot_cap = (state_q == ST_SWAIT) && x_done;
   wire [7:0]  prim_ext = plain ? EXT_ZERO : pins_q[15:8];
   wire drwe_ins_t prim_req = '{ext: prim_ext, code: pins_q[7:0],
                                data: pwd_q};
   wire drwe_ins_t slot_req = '{ext: slot_cmd[15:8],
                                code: slot_cmd[7:0],
                                data: slot_q[sw_i + 4'h1]};
   wire drwe_ins_t x_req = (state_q == ST_PRIM) ? prim_req : slot_req;
   wire        x_ok     = (x_rep.code[7:0] == RC_OK);

   function automatic logic [15:0] mon_pick(input logic [7:0] code);
      case (code)
         MON_FREQ: mon_pick = drive_out_freq;
         MON_CUR:  mon_pick = drive_out_current;
         MON_VOLT: mon_pick = drive_out_voltage;
         MON_PLS:  mon_pick = drive_pulse_mon;
         default:  mon_pick = RST_WORD;
      endcase
   endfunction

   drwe_instr_exec u_exec
   (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .start    (x_start),
      .req      (x_req),
      .running  (drive_running),
      .done     (x_done),
      .rep      (x_rep)
   );

   // Software-written words.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         msel_q <= RST_WORD;
         pins_q <= RST_WORD;
         pwd_q  <= RST_WORD;
         trqw_q <= RST_WORD;
         freq_q <= RST_WORD;
         pls_q  <= RST_WORD;
         hs_q   <= '0;
         cfg_q  <= '0;
      end
      else if (wr)
      begin
         case (paddr)
            A_MSEL:  msel_q <= wd;
            A_PINS:  pins_q <= wd;
            A_PWD:   pwd_q  <= wd;
            A_TRQ:   trqw_q <= wd;
            A_FREQ:  freq_q <= wd;
            A_PLS:   pls_q  <= wd;
            A_HS:    hs_q   <= drwe_hs_t'(pwdata[3:0]);
            A_CFG:   cfg_q  <= drwe_cfg_t'(pwdata[24:0]);
            default: ;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < NSWORD; g++)
      begin : g_slot
         always_ff @(posedge core_clk or posedge sys_rst)
         begin
            if (sys_rst)
               slot_q[g] <= RST_WORD;
            else if (wr && slot_hit && slot_i == 4'(g))
               slot_q[g] <= wd;
         end
      end
   endgenerate

   // PID words: values are percent times one hundred; out-of-range or
   // disabled writes leave the held value alone.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ptgt_q <= RST_WORD;
         pfb_q  <= RST_WORD;
         perr_q <= RST_WORD;
      end
      else if (pid_wr)
      begin
         if (paddr == A_PTGT && drwe_pid_ok(wd, 1'b0))
            ptgt_q <= wd;
         if (paddr == A_PFB && drwe_pid_ok(wd, 1'b0))
            pfb_q <= wd;
         if (paddr == A_PERR && drwe_pid_ok(wd, 1'b1))
            perr_q <= wd;
      end
   end

   // Frequency or torque write on a request rise.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hs_prev_q  <= '0;
         tvol_q     <= RST_WORD;
         tnv_q      <= RST_WORD;
         fvol_q     <= RST_WORD;
         fnv_q      <= RST_WORD;
         fwv_done_q <= 1'b0;
         fwn_done_q <= 1'b0;
      end
      else
      begin
         hs_prev_q <= hs_q;
         if (fw_go && fw_rc == RC_OK)
         begin
            if (trq_mode)
            begin
               tvol_q <= trqw_q;
               if (fwn_rise)
                  tnv_q <= trqw_q;
            end
            else
            begin
               fvol_q <= freq_q;
               if (fwn_rise)
                  fnv_q <= freq_q;
            end
         end
         fwv_done_q <= hs_q.fwv && (fwv_done_q || fwv_rise);
         fwn_done_q <= hs_q.fwn && (fwn_done_q || fwn_rise);
      end
   end

   // Reply word, read data and per-slot replies; all land no later than
   // the matching done bit.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reply_q <= RST_WORD;
         rdata_q <= RST_WORD;
         for (int i = 0; i < NSLOT; i++)
            srep_q[i] <= RST_WORD;
      end
      else
      begin
         if (fw_go)
            reply_q <= plain ? {8'h00, fw_rc}
                             : {reply_q[15:8], fw_rc};
         if (prim_cap)
         begin
            reply_q <= plain ? x_rep.code
                             : {x_rep.code[7:0],
                                (fw_go ? fw_rc : reply_q[7:0])};
            if (x_ok)
               rdata_q <= x_rep.data;
         end
         if (slot_cap)
            srep_q[idx_q] <= x_rep.code;
      end
   end

   // Instruction sequence: primary word, then each enabled slot.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q    <= ST_IDLE;
         idx_q      <= 3'h0;
         ins_done_q <= 1'b0;
      end
      else
      begin
         ins_done_q <= hs_q.exe &&
                       (ins_done_q || state_q == ST_DONE);
         case (state_q)
            ST_IDLE:
               if (exe_rise)
                  state_q <= ST_PRIM;
            ST_PRIM:
               state_q <= ST_PWAIT;
            ST_PWAIT:
               if (x_done)
               begin
                  idx_q   <= 3'h0;
                  state_q <= ST_SLOT;
               end
            ST_SLOT:
               if (slot_end)
                  state_q <= ST_DONE;
               else if (slot_off_w)
                  idx_q <= idx_q + 3'h1;
               else
                  state_q <= ST_SWAIT;
            ST_SWAIT:
               if (x_done)
               begin
                  idx_q   <= idx_q + 3'h1;
                  state_q <= ST_SLOT;
               end
            ST_DONE:
               state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Monitor words.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mon1_q <= RST_WORD;
         mon2_q <= RST_WORD;
      end
      else
      begin
         if (hs_q.mon)
            mon1_q <= mon_pick(msel_q[7:0]);
         if (msel_q[15:8] == 8'h00)
            mon2_q <= pos_pulse ? drive_pulse_mon
                                : drive_out_freq;
         else if (hs_q.mon)
            mon2_q <= mon_pick(msel_q[15:8]);
      end
   end

   // Read selection; write-only words read as zero.
   logic [15:0] rd_val;
   logic        rd_hit;

   always_comb
   begin
      rd_hit = 1'b1;
      rd_val = RST_WORD;
      case (paddr)
         A_MSEL, A_PINS, A_PWD, A_PTGT, A_PFB, A_PERR, A_TRQ, A_FREQ: ;
         A_HS:    rd_val = {12'h000, hs_q};
         A_PLS:   rd_val = pls_q;
         A_MON1:  rd_val = mon1_q;
         A_MON2:  rd_val = mon2_q;
         A_REPLY: rd_val = reply_q;
         A_RDATA: rd_val = rdata_q;
         A_STAT:  rd_val = {11'h000, drive_running, (state_q != ST_IDLE),
                            ins_done_q, fwn_done_q, fwv_done_q};
         A_TVOL:  rd_val = tvol_q;
         A_TNV:   rd_val = tnv_q;
         A_FVOL:  rd_val = fvol_q;
         A_FNV:   rd_val = fnv_q;
         default:
            if (srep_hit)
               rd_val = srep_q[srep_i];
            else if (!slot_hit && paddr != A_CFG)
               rd_hit = 1'b0;
      endcase
   end

   wire [31:0] rd_word = (paddr == A_CFG) ? {7'h00, cfg_q}
                                          : {16'h0000, rd_val};

   // Answer is prepared in setup and presented in the access phase.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q  <= setup;
         pslverr_q <= setup && !rd_hit;
         prdata_q  <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
      end
   end

endmodule // drwe_core

// >>> verif/drwe_core_sva.sv
`timescale 1ns/1ps
module drwe_core_chk
   import drwe_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] pid_target_out,
   input wire logic        freq_write_volatile_done,
   input wire logic        freq_write_nonvolatile_done,
   input wire logic        instruction_done
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   wire hs_wr = psel && penable && pwrite && paddr == A_HS;
   wire tg_wr = psel && penable && pwrite && paddr == A_PTGT;
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside access");
   pid_in_range_a: assert property (pid_target_out <= 16'h2710)
      else $error("pid target above full scale");
   pid_write_only_a: assert property ($changed(pid_target_out)
      |-> $past(tg_wr)) else $error("pid target changed without write");
   vol_done_rise_a: assert property ($rose(freq_write_volatile_done)
      |-> $past(hs_wr && pwdata[1], 2)) else $error("volatile done early");
   nv_done_rise_a: assert property ($rose(freq_write_nonvolatile_done)
      |-> $past(hs_wr && pwdata[2], 2)) else $error("nonvolatile done early");
   ins_done_drop_a: assert property (hs_wr && !pwdata[3]
      |-> ##[1:3] !instruction_done) else $error("done not dropped");
   ins_not_instant_a: assert property (hs_wr && pwdata[3]
      && !instruction_done |=> !instruction_done [*4])
      else $error("instruction done too soon");
endmodule // drwe_core_chk
bind drwe_core drwe_core_chk chk_u (.core_clk(core_clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pid_target_out(pid_target_out),
   .freq_write_volatile_done(freq_write_volatile_done),
   .freq_write_nonvolatile_done(freq_write_nonvolatile_done),
   .instruction_done(instruction_done));

// >>> verif/drwe_drive_model.sv
`timescale 1ns/1ps
module drwe_drive_model
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        step,
   output logic      [15:0] cnt_q
);
   // Drive quantities move only on step, so a monitor read sees fixed data.
   always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
         cnt_q <= 16'h0A51;
      else if (step)
         cnt_q <= cnt_q + 16'h0123;
endmodule // drwe_drive_model

// >>> verif/drive_remote_word_exchange_tb_top.sv
`timescale 1ns/1ps
module drive_remote_word_exchange_tb_top
   import drwe_pkg::*;
;
   logic        core_clk, sys_rst, psel, penable, pwrite, run, step, er;
   logic [7:0]  paddr, s;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr;
   logic [15:0] q, f_v, f_n, t_v, t_n, p_t, p_f, p_e, v, h, e_t, e_e, w;
   int          n_errors, checked;
   logic [15:0] cor [4] = '{16'h2710, 16'h2711, 16'hD8F0, 16'hD8EF};
   logic [7:0]  sel [5] = '{8'h32, 8'h33, 8'h3C, 8'h3D, 8'h00};
   wire  [15:0] d_f = q;
   wire  [15:0] d_c = q ^ 16'h5A5A;
   wire  [15:0] d_v = ~q;
   wire  [15:0] d_p = q + 16'h0011;
   drwe_drive_model drv_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .step(step), .cnt_q(q));
   drwe_core dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drive_running(run), .drive_out_freq(d_f), .drive_out_current(d_c),
      .drive_out_voltage(d_v), .drive_pulse_mon(d_p),
      .freq_volatile_out(f_v), .freq_nonvolatile_out(f_n),
      .torque_value_volatile_param(t_v),
      .torque_value_nonvolatile_param(t_n), .pid_target_out(p_t),
      .pid_feedback_out(p_f), .pid_error_out(p_e),
      .freq_write_volatile_done(), .freq_write_nonvolatile_done(),
      .instruction_done());
   task automatic test_done();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] sn, ex);
      // Values are taken when the check is called and compared at the next falling edge.
      @(negedge core_clk);
      checked++;
      if (sn !== ex)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, sn);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
         @(posedge core_clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Raise one request bit, poll its done flag, take the reply, then drop.
   task automatic hs(input int b);
      int k;
      k = 0;
      apb(1'b1, A_HS, 32'h1 << b);
      do
         apb(1'b0, A_STAT, 32'h0);
      while (rd[b == 3 ? 2 : b - 1] !== 1'b1 && ++k < 40);
      chk("done_bit", {31'h0, rd[b == 3 ? 2 : b - 1]}, 32'h1);
      apb(1'b0, A_REPLY, 32'h0);
      h = rd[15:0];
      apb(1'b1, A_HS, 32'h0);
   endtask
   task automatic ins(input logic [15:0] c, d);
      apb(1'b1, A_PINS, {16'h0, c});
      apb(1'b1, A_PWD, {16'h0, d});
      hs(3);
   endtask
   function automatic logic [15:0] pid_exp(input logic [15:0] o, n,
      input logic sg, input logic [7:0] sl);
      int x;
      x = $signed(n);
      if (sl == 8'h00 || x > 10000 || x < (sg ? -10000 : 0))
         return o;
      return n;
   endfunction
   function automatic logic [15:0] mon_exp(input logic [7:0] c);
      case (c)
         MON_FREQ: return d_f;
         MON_CUR:  return d_c;
         MON_VOLT: return d_v;
         MON_PLS:  return d_p;
         default:  return 16'h0000;
      endcase
   endfunction
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial
   begin
      #2000000;
      n_errors++;
      test_done();
   end
   initial
   begin
      {sys_rst, psel, penable, pwrite, run, step} = 6'h20;
      {paddr, pwdata, e_t, e_e} = '0;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      void'($urandom(30));
      apb(1'b0, A_REPLY, 32'h0);
      chk("reply_reset", rd, 32'h0);
      for (int k = 0; k < 5; k++)
         apb(1'b1, A_SLOT + 8'(k * 8), 32'hFFFF);
      for (int i = 0; i < 15; i++)
      begin
         s = sel[i % 5];
         v = i < 4 ? cor[i] : 16'($urandom);
         apb(1'b1, A_CFG, {16'h0, s, 8'h00});
         apb(1'b1, A_PTGT, {16'h0, v});
         apb(1'b1, A_PFB, {16'h0, v});
         apb(1'b1, A_PERR, {16'h0, v});
         e_t = pid_exp(e_t, v, 1'b0, s);
         e_e = pid_exp(e_e, v, 1'b1, s);
         chk("pid_target", p_t, e_t);
         chk("pid_feedback", p_f, e_t);
         chk("pid_error", p_e, e_e);
      end
      for (int b = 1; b < 3; b++)
      begin
         v = 16'($urandom_range(0, 40000));
         apb(1'b1, A_FREQ, {16'h0, v});
         hs(b);
         chk("freq", b == 1 ? f_v : f_n, v);
         chk("freq_reply", h, 32'h0);
         apb(1'b1, A_FREQ, 32'h9C41);
         hs(b);
         chk("freq_bad_reply", h, 32'h3);
      end
      w = 16'($urandom);
      v = 16'($urandom);
      apb(1'b1, A_SLOT + 8'h08, 32'h0186);
      apb(1'b1, A_SLOT + 8'h0C, {16'h0, w});
      ins(16'h0085, v);
      chk("ins_reply", h, 32'h0);
      apb(1'b0, A_SREP + 8'h08, 32'h0);
      chk("slot_reply", rd, 32'h0);
      ins(16'h0005, 16'h0000);
      apb(1'b0, A_RDATA, 32'h0);
      chk("read_data", rd, {16'h0, v});
      ins(16'h0010, 16'h0000);
      chk("sel_error", h, 32'h2);
      apb(1'b1, A_CFG, 32'h0E);
      hs(1);
      run <= 1'b1;
      ins(16'h0085, v);
      run <= 1'b0;
      chk("split_reply", h, 32'h0103);
      ins(16'h0106, 16'h0000);
      apb(1'b0, A_RDATA, 32'h0);
      chk("slot_param", rd, {16'h0, w});
      v = 16'($urandom_range(0, 32767));
      apb(1'b1, A_CFG, 32'h0103320E);
      apb(1'b1, A_TRQ, {16'h0, v});
      hs(2);
      chk("torque_vol", t_v, v);
      chk("torque_nv", t_n, v);
      apb(1'b1, A_CFG, 32'h0105320E);
      apb(1'b1, A_TRQ, {16'h0, 1'b1, v[14:0]});
      hs(1);
      chk("torque_bad", {h[7:0], t_v}, {8'h03, v});
      step <= 1'b1;
      apb(1'b1, A_HS, 32'h1);
      step <= 1'b0;
      for (int c = 0; c < 6; c++)
      begin
         apb(1'b1, A_MSEL, {16'h0, 8'h03, 8'(c)});
         apb(1'b0, A_MON1, 32'h0);
         chk("mon1", rd, {16'h0, mon_exp(8'(c))});
         apb(1'b0, A_MON2, 32'h0);
         chk("mon2", rd, {16'h0, d_v});
      end
      apb(1'b1, A_MSEL, 32'h0);
      for (int p = 0; p < 3; p++)
      begin
         apb(1'b1, A_CFG, p > 0 ? 32'h00300000 : 32'h0);
         apb(1'b1, A_PLS, p > 1 ? 32'h270F : 32'h0);
         apb(1'b0, A_MON2, 32'h0);
         chk("mon2_sel", rd, {16'h0, p == 1 ? d_p : d_f});
      end
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped", {31'h0, er}, 32'h1);
      test_done();
   end
endmodule // drive_remote_word_exchange_tb_top
